// [rtl/div_unit.sv]
`timescale 1ns/10ps
`default_nettype none

// Restoring divider, two quotient bits per cycle; last two bits are combinational
module div_unit (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [7:0] dividend,
    input  wire logic [7:0] divisor,
    output logic [7:0]      quotient,
    output logic [7:0]      remainder
);

    logic [15:0] rq_r;
    logic [15:0] rq_nxt;
    logic [7:0]  dv_r;
    logic [7:0]  dv_nxt;
    logic [15:0] fin;

    function automatic logic [15:0] div_step(input logic [15:0] rq, input logic [7:0] dv);
        logic [8:0] t;
        logic       ge;
        begin
            t  = {rq[15:8], rq[7]};
            ge = (t >= {1'b0, dv});
            if (ge) begin
                t = t - {1'b0, dv};
            end
            div_step = {t[7:0], rq[6:0], ge};
        end
    endfunction : div_step

    always_comb begin
        if (start) begin
            rq_nxt = div_step(div_step({8'h00, dividend}, divisor), divisor);
            dv_nxt = divisor;
        end else begin
            rq_nxt = div_step(div_step(rq_r, dv_r), dv_r);
            dv_nxt = dv_r;
        end
        fin = div_step(div_step(rq_r, dv_r), dv_r);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rq_r <= 16'h0000;
            dv_r <= 8'h00;
        end else begin
            rq_r <= rq_nxt;
            dv_r <= dv_nxt;
        end
    end

    assign quotient  = fin[7:0];
    assign remainder = fin[15:8];

endmodule : div_unit

`default_nettype wire

// [rtl/exec_pkg.sv]
package exec_pkg;

    // Opcodes and opcode groups
    localparam logic [7:0] OP_DEC_ACC   = 8'h14;
    localparam logic [7:0] OP_DEC_DIR   = 8'h15;
    localparam logic [6:0] OP_DEC_IND   = 7'h0b;
    localparam logic [4:0] OP_DEC_REG   = 5'h03;
    localparam logic [7:0] OP_DIV       = 8'h84;
    localparam logic [4:0] OP_CDB_REG   = 5'h1b;
    localparam logic [7:0] OP_CDB_DIR   = 8'hd5;
    localparam logic [6:0] OP_INC_IND   = 7'h03;
    localparam logic [7:0] OP_INC_ACC   = 8'h04;
    localparam logic [7:0] OP_INC_DIR   = 8'h05;
    localparam logic [7:0] OP_INC_PTR   = 8'ha3;
    localparam logic [4:0] OP_INC_REG   = 5'h01;
    localparam logic [7:0] OP_BIT_SET   = 8'h20;

    // Special function register addresses and bit RAM base
    localparam logic [7:0] SFR_ACC      = 8'he0;
    localparam logic [7:0] SFR_B        = 8'hf0;
    localparam logic [7:0] SFR_STATUS   = 8'hd0;
    localparam logic [7:0] SFR_PTR_LO   = 8'h82;
    localparam logic [7:0] SFR_PTR_HI   = 8'h83;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;

    // Status word field positions
    localparam int STAT_CY     = 7;
    localparam int STAT_BANK_H = 4;
    localparam int STAT_BANK_L = 3;
    localparam int STAT_RANGE  = 2;
    localparam int STAT_PAR    = 0;

    // Machine cycles per instruction, counted after the accept cycle; divider round count
    localparam logic [1:0] EXTRA_ONE  = 2'h0;
    localparam logic [1:0] EXTRA_TWO  = 2'h1;
    localparam logic [1:0] EXTRA_DIV  = 2'h3;
    localparam logic [1:0] DIV_ROUNDS = 2'h3;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_PC   = 16'h0000;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte2;
        logic [7:0] byte3;
    } instr_s;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] status;
        logic [7:0] ptr_hi;
        logic [7:0] ptr_lo;
    } core_s;

    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_DIV} exec_state_e;

endpackage : exec_pkg

// [rtl/inc_dec_div_branch_exec.sv]
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Accumulator decrement: one byte, one cycle, parity
// - Bank register decrement picked by low three bits
// - Direct location decrement, two bytes, one cycle
// - Unsigned divide: quotient to acc, remainder B
// - Divide clears carry; range flag marks zero divisor
// - Zero divisor leaves acc and B untouched
// - Register count-down: pc plus two, branch nonzero
// - Direct count-down: three bytes, branch if nonzero
// - Indirect increment through bank register zero/one
// - Accumulator increment: one cycle, parity update
// - Sixteen-bit pointer increment, carry, two cycles
// - Bank register increment picked by low bits
// - Direct increment, special registers included
// - Branch when addressed bit set, bit unchanged
module inc_dec_div_branch_exec (
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  wire logic            req_valid,
    input  wire exec_pkg::instr_s req,
    input  wire logic [7:0]      peek_addr,
    output logic                 ready,
    output logic                 done,
    output logic                 unsupported,
    output logic [15:0]          pc,
    output exec_pkg::core_s      core,
    output logic [7:0]           peek_data
);

    logic [7:0]           mem [0:255];
    exec_pkg::exec_state_e state_r;
    exec_pkg::exec_state_e state_nxt;
    logic [1:0]           wait_r;
    logic [1:0]           wait_nxt;
    exec_pkg::core_s      core_r;
    exec_pkg::core_s      core_nxt;
    logic [15:0]          pc_r;
    logic [15:0]          pc_nxt;
    logic                 ready_r;
    logic                 ready_nxt;
    logic                 done_r;
    logic                 done_nxt;
    logic                 unsup_r;
    logic                 unsup_nxt;
    logic [7:0]           peek_r;
    logic                 mem_we;
    logic [7:0]           mem_wa;
    logic [7:0]           mem_wd;
    logic                 accept;
    logic                 div_start;
    logic [7:0]           div_q;
    logic [7:0]           div_r;
    logic [7:0]           bank_base;
    logic [7:0]           reg_addr;
    logic [7:0]           ind_addr;
    logic [7:0]           bit_addr;
    logic [7:0]           dir_val;
    logic [7:0]           bit_byte;
    logic                 bit_val;
    logic [15:0]          ptr_inc;
    logic [7:0]           val;
    logic                 dir_hit;
    logic                 acc_write;

    // Reads a direct location; upper half holds the dedicated registers
    function automatic logic [7:0] rd_dir(input logic [7:0] a, input exec_pkg::core_s c,
                                          input logic [7:0] m);
        begin
            case (a)
                exec_pkg::SFR_ACC:    rd_dir = c.acc;
                exec_pkg::SFR_B:      rd_dir = c.b;
                exec_pkg::SFR_STATUS: rd_dir = c.status;
                exec_pkg::SFR_PTR_LO: rd_dir = c.ptr_lo;
                exec_pkg::SFR_PTR_HI: rd_dir = c.ptr_hi;
                default:              rd_dir = m;
            endcase
        end
    endfunction : rd_dir

    function automatic logic is_dedicated(input logic [7:0] a);
        begin
            is_dedicated = (a == exec_pkg::SFR_ACC) || (a == exec_pkg::SFR_B)
                        || (a == exec_pkg::SFR_STATUS) || (a == exec_pkg::SFR_PTR_LO)
                        || (a == exec_pkg::SFR_PTR_HI);
        end
    endfunction : is_dedicated

    assign accept    = req_valid & ready_r;
    assign div_start = accept && (req.opcode == exec_pkg::OP_DIV);

    div_unit u_div (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .start     (div_start),
        .dividend  (core_r.acc),
        .divisor   (core_r.b),
        .quotient  (div_q),
        .remainder (div_r)
    );

    // Operand addressing
    always_comb begin
        bank_base = {3'b000, core_r.status[exec_pkg::STAT_BANK_H:exec_pkg::STAT_BANK_L], 3'b000};
        reg_addr  = bank_base | {5'b00000, req.opcode[2:0]};
        ind_addr  = mem[bank_base | {7'b0000000, req.opcode[0]}];
        dir_val   = rd_dir(req.byte2, core_r, mem[req.byte2]);
        bit_addr  = req.byte2[7] ? {req.byte2[7:3], 3'b000}
                                 : exec_pkg::BIT_RAM_BASE + {4'h0, req.byte2[6:3]};
        bit_byte  = rd_dir(bit_addr, core_r, mem[bit_addr]);
        bit_val   = bit_byte[req.byte2[2:0]];
        ptr_inc   = {core_r.ptr_hi, core_r.ptr_lo} + 16'h0001;
    end

    always_comb begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        core_nxt  = core_r;
        pc_nxt    = pc_r;
        ready_nxt = ready_r;
        done_nxt  = 1'b0;
        unsup_nxt = 1'b0;
        mem_we    = 1'b0;
        mem_wa    = 8'h00;
        mem_wd    = 8'h00;
        val       = 8'h00;
        dir_hit   = 1'b0;
        acc_write = 1'b0;
        case (state_r)
            exec_pkg::ST_IDLE: begin
                if (accept) begin
                    wait_nxt = exec_pkg::EXTRA_ONE;
                    pc_nxt   = pc_r + 16'h0001;
                    if (req.opcode == exec_pkg::OP_DEC_ACC) begin
                        core_nxt.acc = core_r.acc - 8'h01;
                        acc_write    = 1'b1;
                    end else if (req.opcode == exec_pkg::OP_INC_ACC) begin
                        core_nxt.acc = core_r.acc + 8'h01;
                        acc_write    = 1'b1;
                    end else if (req.opcode[7:3] == exec_pkg::OP_DEC_REG) begin
                        mem_we = 1'b1;
                        mem_wa = reg_addr;
                        mem_wd = mem[reg_addr] - 8'h01;
                    end else if (req.opcode[7:3] == exec_pkg::OP_INC_REG) begin
                        mem_we = 1'b1;
                        mem_wa = reg_addr;
                        mem_wd = mem[reg_addr] + 8'h01;
                    end else if (req.opcode[7:1] == exec_pkg::OP_INC_IND) begin
                        mem_we = 1'b1;
                        mem_wa = ind_addr;
                        mem_wd = mem[ind_addr] + 8'h01;
                    end else if (req.opcode[7:1] == exec_pkg::OP_DEC_IND) begin
                        mem_we = 1'b1;
                        mem_wa = ind_addr;
                        mem_wd = mem[ind_addr] - 8'h01;
                    end else if (req.opcode == exec_pkg::OP_DEC_DIR
                              || req.opcode == exec_pkg::OP_INC_DIR) begin
                        pc_nxt  = pc_r + 16'h0002;
                        val     = (req.opcode == exec_pkg::OP_INC_DIR) ? dir_val + 8'h01
                                                                      : dir_val - 8'h01;
                        dir_hit = 1'b1;
                    end else if (req.opcode == exec_pkg::OP_INC_PTR) begin
                        {core_nxt.ptr_hi, core_nxt.ptr_lo} = ptr_inc;
                        wait_nxt = exec_pkg::EXTRA_TWO;
                    end else if (req.opcode[7:3] == exec_pkg::OP_CDB_REG) begin
                        wait_nxt = exec_pkg::EXTRA_TWO;
                        mem_we   = 1'b1;
                        mem_wa   = reg_addr;
                        mem_wd   = mem[reg_addr] - 8'h01;
                        pc_nxt   = pc_r + 16'h0002;
                        if (mem_wd != 8'h00) begin
                            pc_nxt = pc_r + 16'h0002 + {{8{req.byte2[7]}}, req.byte2};
                        end
                    end else if (req.opcode == exec_pkg::OP_CDB_DIR) begin
                        wait_nxt = exec_pkg::EXTRA_TWO;
                        val      = dir_val - 8'h01;
                        dir_hit  = 1'b1;
                        pc_nxt   = pc_r + 16'h0003;
                        if (val != 8'h00) begin
                            pc_nxt = pc_r + 16'h0003 + {{8{req.byte3[7]}}, req.byte3};
                        end
                    end else if (req.opcode == exec_pkg::OP_BIT_SET) begin
                        // Read only: the bit is never written back
                        wait_nxt = exec_pkg::EXTRA_TWO;
                        pc_nxt   = pc_r + 16'h0003;
                        if (bit_val) begin
                            pc_nxt = pc_r + 16'h0003 + {{8{req.byte3[7]}}, req.byte3};
                        end
                    end else if (req.opcode == exec_pkg::OP_DIV) begin
                        wait_nxt = exec_pkg::EXTRA_DIV;
                    end else begin
                        // Unknown opcodes are skipped as one byte so the stream keeps moving
                        unsup_nxt = 1'b1;
                    end
                    if (dir_hit) begin
                        if (is_dedicated(req.byte2)) begin
                            case (req.byte2)
                                exec_pkg::SFR_ACC: begin
                                    core_nxt.acc = val;
                                    acc_write    = 1'b1;
                                end
                                exec_pkg::SFR_B:      core_nxt.b      = val;
                                exec_pkg::SFR_STATUS: core_nxt.status = val;
                                exec_pkg::SFR_PTR_LO: core_nxt.ptr_lo = val;
                                exec_pkg::SFR_PTR_HI: core_nxt.ptr_hi = val;
                                default:              core_nxt.b      = core_r.b;
                            endcase
                        end else begin
                            mem_we = 1'b1;
                            mem_wa = req.byte2;
                            mem_wd = val;
                        end
                    end
                    if (acc_write) begin
                        core_nxt.status[exec_pkg::STAT_PAR] = ^core_nxt.acc;
                    end
                    if (req.opcode == exec_pkg::OP_DIV) begin
                        state_nxt = exec_pkg::ST_DIV;
                        ready_nxt = 1'b0;
                    end else if (wait_nxt != exec_pkg::EXTRA_ONE) begin
                        state_nxt = exec_pkg::ST_HOLD;
                        ready_nxt = 1'b0;
                    end else begin
                        done_nxt = 1'b1;
                    end
                end
            end
            exec_pkg::ST_HOLD: begin
                wait_nxt = wait_r - 2'h1;
                if (wait_r == 2'h1) begin
                    state_nxt = exec_pkg::ST_IDLE;
                    ready_nxt = 1'b1;
                    done_nxt  = 1'b1;
                end
            end
            exec_pkg::ST_DIV: begin
                wait_nxt = wait_r - 2'h1;
                if (wait_r == 2'h1) begin
                    // Divider has run DIV_ROUNDS rounds; its final bits are combinational
                    core_nxt.status[exec_pkg::STAT_CY] = 1'b0;
                    if (core_r.b == 8'h00) begin
                        core_nxt.status[exec_pkg::STAT_RANGE] = 1'b1;
                    end else begin
                        core_nxt.status[exec_pkg::STAT_RANGE] = 1'b0;
                        core_nxt.acc = div_q;
                        core_nxt.b   = div_r;
                    end
                    core_nxt.status[exec_pkg::STAT_PAR] = ^core_nxt.acc;
                    state_nxt = exec_pkg::ST_IDLE;
                    ready_nxt = 1'b1;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = exec_pkg::ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= exec_pkg::ST_IDLE;
            wait_r  <= 2'h0;
            core_r  <= '{exec_pkg::RST_BYTE, exec_pkg::RST_BYTE, exec_pkg::RST_BYTE,
                         exec_pkg::RST_BYTE, exec_pkg::RST_BYTE};
            pc_r    <= exec_pkg::RST_PC;
            ready_r <= 1'b1;
            done_r  <= 1'b0;
            unsup_r <= 1'b0;
            peek_r  <= 8'h00;
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            core_r  <= core_nxt;
            pc_r    <= pc_nxt;
            ready_r <= ready_nxt;
            done_r  <= done_nxt;
            unsup_r <= unsup_nxt;
            peek_r  <= rd_dir(peek_addr, core_r, mem[peek_addr]);
        end
    end

    // Memory contents are not cleared by reset; software initialises them
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Plain register copies, so no combinational path reaches a pin
    assign ready       = ready_r;
    assign done        = done_r;
    assign unsupported = unsup_r;
    assign pc          = pc_r;
    assign core        = core_r;
    assign peek_data   = peek_r;

endmodule : inc_dec_div_branch_exec

`default_nettype wire

// [verif/exec_checker_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module exec_checker (
    input wire logic             clk_sys,
    input wire logic             rst,
    input wire logic             req_valid,
    input wire exec_pkg::instr_s req,
    input wire logic [7:0]       peek_addr,
    input wire logic             ready,
    input wire logic             done,
    input wire logic             unsupported,
    input wire logic [15:0]      pc,
    input wire exec_pkg::core_s  core,
    input wire logic [7:0]       peek_data
);
    logic        take;
    logic [15:0] off3;
    logic        acc_bit;
    assign take    = req_valid && ready;
    assign off3    = {{8{req.byte3[7]}}, req.byte3};
    assign acc_bit = core.acc[req.byte2[2:0]];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_take_div;
        take && req.opcode == exec_pkg::OP_DIV;
    endsequence
    sequence s_busy3;
        (!ready && !done) [*3];
    endsequence

    property p_div_len;
        s_take_div |=> s_busy3 ##1 (done && ready);
    endproperty
    property p_div_quot;
        s_take_div ##0 core.b != 8'h0 |-> ##4 (core.acc == 8'($past(core.acc, 4) / $past(core.b, 4))
            && core.b == 8'($past(core.acc, 4) % $past(core.b, 4)));
    endproperty
    property p_div_flags;
        s_take_div |-> ##4 (!core.status[exec_pkg::STAT_CY]
            && core.status[exec_pkg::STAT_RANGE] == ($past(core.b, 4) == 8'h0));
    endproperty
    property p_div_zero;
        s_take_div ##0 core.b == 8'h0 |-> ##4 (core.acc == $past(core.acc, 4) && core.b == 8'h0);
    endproperty
    property p_inc_acc;
        take && req.opcode == exec_pkg::OP_INC_ACC |=> done && ready
            && core.acc == 8'($past(core.acc) + 8'h1)
            && core.status[exec_pkg::STAT_PAR] == ^core.acc;
    endproperty
    property p_dec_acc;
        take && req.opcode == exec_pkg::OP_DEC_ACC |=> done
            && core.acc == 8'($past(core.acc) - 8'h1)
            && core.status[exec_pkg::STAT_PAR] == ^core.acc;
    endproperty
    property p_ptr;
        take && req.opcode == exec_pkg::OP_INC_PTR |=> !ready ##1 (done
            && {core.ptr_hi, core.ptr_lo} == 16'($past({core.ptr_hi, core.ptr_lo}, 2) + 16'h1));
    endproperty
    property p_cdb_dir;
        take && req.opcode == exec_pkg::OP_CDB_DIR && req.byte2 == exec_pkg::SFR_B |=>
            core.b == 8'($past(core.b) - 8'h1)
            && pc == 16'($past(pc) + 16'h3 + ((core.b != 8'h0) ? $past(off3) : 16'h0));
    endproperty
    property p_bit_set;
        take && req.opcode == exec_pkg::OP_BIT_SET && req.byte2[7:3] == 5'h1c |=>
            core.acc == $past(core.acc)
            && pc == 16'($past(pc) + 16'h3 + ($past(acc_bit) ? $past(off3) : 16'h0));
    endproperty
    property p_reg_op;
        take && (req.opcode[7:3] == exec_pkg::OP_DEC_REG || req.opcode[7:3] == exec_pkg::OP_INC_REG)
            |=> done && pc == 16'($past(pc) + 16'h1) && core == $past(core);
    endproperty

    a_div_len: assert property (p_div_len) else $error("divide length wrong");
    a_div_quot: assert property (p_div_quot) else $error("divide result wrong");
    a_div_flags: assert property (p_div_flags) else $error("divide flags wrong");
    a_div_zero: assert property (p_div_zero) else $error("zero divisor altered operands");
    a_inc_acc: assert property (p_inc_acc) else $error("acc increment wrong");
    a_dec_acc: assert property (p_dec_acc) else $error("acc decrement wrong");
    a_ptr: assert property (p_ptr) else $error("pointer increment wrong");
    a_cdb_dir: assert property (p_cdb_dir) else $error("count-down branch wrong");
    a_bit_set: assert property (p_bit_set) else $error("bit branch wrong");
    a_reg_op: assert property (p_reg_op) else $error("register op disturbed state");
endmodule : exec_checker

bind inc_dec_div_branch_exec exec_checker u_chk (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req(req), .peek_addr(peek_addr), .ready(ready), .done(done),
    .unsupported(unsupported), .pc(pc), .core(core), .peek_data(peek_data));

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %0t %s", $time, m); end end

module testbench;
    logic             clk_sys, rst, req_valid, ready, done, unsupported;
    exec_pkg::instr_s req;
    exec_pkg::core_s  core;
    logic [7:0]       peek_addr, peek_data, ea, eb, ep, eh, el, v;
    logic [15:0]      pc, epc;
    logic [31:0]      seed;
    int               n_mismatch, n_tests, k;
    // Outside this block's opcode set, so it must be skipped and flagged
    localparam logic [7:0] FOREIGN_OP = 8'ha5;

    inc_dec_div_branch_exec DUT (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
        .peek_addr(peek_addr), .ready(ready), .done(done), .unsupported(unsupported), .pc(pc),
        .core(core), .peek_data(peek_data));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Request held until the next instruction or idle takes over, never lowered in between
    task automatic exec(input logic [7:0] op, b2, b3, input int n);
        logic [7:0] r;
        req_valid = 1'b1;
        req = '{op, b2, b3};
        @(posedge clk_sys) #1;
        k = 1;
        while (done !== 1'b1 && k < 8) begin
            @(posedge clk_sys) #1;
            k++;
        end
        epc = epc + 16'h1;
        r = (op == exec_pkg::OP_INC_DIR) ? 8'h01 : 8'hff;
        case (op)
            exec_pkg::OP_INC_ACC: ea = ea + 8'h1;
            exec_pkg::OP_DEC_ACC: ea = ea - 8'h1;
            exec_pkg::OP_INC_PTR: {eh, el} = {eh, el} + 16'h1;
            exec_pkg::OP_INC_DIR, exec_pkg::OP_DEC_DIR: begin
                epc = epc + 16'h1;
                if (b2 == exec_pkg::SFR_ACC) ea = ea + r;
                else if (b2 == exec_pkg::SFR_B) eb = eb + r;
                else if (b2 == exec_pkg::SFR_PTR_LO) el = el + r;
            end
            exec_pkg::OP_DIV: begin
                ep[exec_pkg::STAT_CY] = 1'b0;
                ep[exec_pkg::STAT_RANGE] = (eb == 8'h0);
                if (eb != 8'h0) {ea, eb} = {ea / eb, ea % eb};
            end
            exec_pkg::OP_CDB_DIR: begin
                epc = epc + 16'h2;
                eb = eb - 8'h1;
                if (eb != 8'h0) epc = epc + {{8{b3[7]}}, b3};
            end
            exec_pkg::OP_BIT_SET: begin
                epc = epc + 16'h2;
                if (ea[b2[2:0]]) epc = epc + {{8{b3[7]}}, b3};
            end
            default: ;
        endcase
        ep[exec_pkg::STAT_PAR] = ^ea;
        `CHK(k, n, "cycle count")
        `CHK(pc, epc, "program counter")
        `CHK(core, {ea, eb, ep, eh, el}, "core state")
        `CHK(unsupported, (op == FOREIGN_OP), "foreign opcode flag")
    endtask : exec

    // Operands can only be reached by stepping, so divide setup walks there
    task automatic set_ab(input logic [7:0] a, bv);
        while (ea != a) exec(exec_pkg::OP_INC_ACC, 8'h0, 8'h0, 1);
        while (eb != bv) exec(exec_pkg::OP_INC_DIR, exec_pkg::SFR_B, 8'h0, 1);
    endtask : set_ab

    // Idle one cycle so the observation port catches up with the finished state
    task automatic peek(input logic [7:0] a, e);
        req_valid = 1'b0;
        peek_addr = a;
        @(posedge clk_sys) #1;
        `CHK(peek_data, e, "observed location")
    endtask : peek

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial begin
        #200_000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        peek_addr = exec_pkg::SFR_B;
        {ea, eb, ep, eh, el} = '0;
        epc = '0;
        seed = 32'h465b;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        exec(exec_pkg::OP_DEC_ACC, 8'h0, 8'h0, 1);
        exec(exec_pkg::OP_INC_ACC, 8'h0, 8'h0, 1);
        exec(exec_pkg::OP_DEC_DIR, exec_pkg::SFR_PTR_LO, 8'h0, 1);
        exec(exec_pkg::OP_INC_PTR, 8'h0, 8'h0, 2);
        exec(exec_pkg::OP_DEC_DIR, exec_pkg::SFR_ACC, 8'h0, 1);
        exec(exec_pkg::OP_INC_DIR, exec_pkg::SFR_ACC, 8'h0, 1);
        exec(FOREIGN_OP, 8'h0, 8'h0, 1);
        peek(exec_pkg::SFR_PTR_HI, eh);
        peek(exec_pkg::SFR_ACC, ea);
        $display("test steps done");
        for (int i = 0; i < 8; i++) begin
            exec({exec_pkg::OP_DEC_REG, i[2:0]}, 8'h0, 8'h0, 1);
            exec({exec_pkg::OP_INC_REG, i[2:0]}, 8'h0, 8'h0, 1);
            exec({exec_pkg::OP_INC_IND, i[0]}, 8'h0, 8'h0, 1);
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : seed[15:8];
            set_ab(seed[7:0], v);
            exec(exec_pkg::OP_DIV, 8'h0, 8'h0, 4);
        end
        peek(exec_pkg::SFR_B, eb);
        $display("test divide done");
        set_ab(ea, 8'h02);
        exec(exec_pkg::OP_CDB_DIR, exec_pkg::SFR_B, 8'hf0, 2);
        exec(exec_pkg::OP_CDB_DIR, exec_pkg::SFR_B, 8'hf0, 2);
        set_ab(8'ha5, eb);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            exec(exec_pkg::OP_BIT_SET, {5'h1c, i[2:0]}, seed[7:0], 2);
        end
        peek(exec_pkg::SFR_STATUS, ep);
        $display("test branches done");
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
